// [src/hvsp_port.sv]
`timescale 1ns/1ps
module hvsp_port (
  // system clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // reset pin seen at high voltage
  input wire logic i_hv_reset,
  // fuse: eeprom kept over erase when high
  input wire logic i_keep_eeprom_fuse,
  // programming link pins
  input wire logic i_prog_serial_clock,
  input wire logic i_prog_data_in,
  input wire logic i_prog_instr_in,
  input wire logic i_prog_data_out,
  output logic o_prog_data_out,
  output logic o_prog_data_out_oe,
  // status
  output logic o_prog_mode,
  output logic o_busy,
  output logic [7:0] o_lock_bits
);
  // ------------------------------------------------
  // declarations
  // ------------------------------------------------
  logic [3:0] pin_m_q; // first sync stage
  logic [3:0] pin_s_q; // {hv, out pin, instr, data}
  logic hv_d_q; // delayed hv level
  logic hv_rise;
  logic prog_q; // in programming mode
  logic [11:0] hold_q; // entry hold counter
  logic link_rst_n;
  // link domain
  logic [3:0] bit_q; // bit position in frame
  logic [10:0] din_sh_q; // data input shifter
  logic [10:0] iin_sh_q; // instr input shifter
  logic [10:0] out_sh_q; // read data shifter
  hvsp_pkg::hvsp_frame_t frm_q; // last whole frame
  logic frm_tgl_q; // flips per frame
  // crossings into system domain
  logic tgl_m_q, tgl_s_q, tgl_d_q;
  logic bit_m_q, bit_s_q;
  logic frm_stb;
  logic [7:0] f_instr, f_data;
  // command and operands
  logic [7:0] cmd_q, addr_lo_q, addr_hi_q;
  logic [7:0] dlo_q, dhi_q;
  logic arm_q; // first write frame seen
  logic rd_act_q; // next frame shifts data
  logic [7:0] rd_byte_q; // byte to shift out
  logic start;
  // engine
  hvsp_pkg::hvsp_state_t state_q;
  logic [11:0] cnt_q;
  logic [11:0] fl_addr; // word address
  logic [8:0] ee_addr; // byte address
  logic [11:0] fl_waddr;
  logic [8:0] ee_waddr;
  // storage
  logic [15:0] flash_q [hvsp_pkg::FL_WORDS];
  logic [7:0] eep_q [hvsp_pkg::EE_BYTES];
  logic [15:0] fbuf_q [hvsp_pkg::FL_PAGE];
  logic [7:0] ebuf_q [hvsp_pkg::EE_PAGE];
  logic [3:0] emask_q; // loaded eeprom bytes

  // ------------------------------------------------
  // pin synchronisers and mode entry
  // ------------------------------------------------
  // pins are async to i_clk_sys; two stages first
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      hv_d_q <= 1'b0;
    end else begin
      pin_m_q <= {i_hv_reset, i_prog_data_out,
                  i_prog_instr_in, i_prog_data_in};
      pin_s_q <= pin_m_q;
      hv_d_q <= pin_s_q[3];
    end
  end

  assign hv_rise = pin_s_q[3] & ~hv_d_q;

  // mode flag: signature caught at high voltage edge
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prog_q <= 1'b0;
    end else if (!pin_s_q[3]) begin
      prog_q <= 1'b0; // [RULE_06]
    end else if (hv_rise) begin
      prog_q <= (pin_s_q[2:0] == hvsp_pkg::ENTRY_SIG); // [RULE_02]
    end
  end

  // wait out the programmer's hold before driving
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_q <= '0;
    end else if (!prog_q) begin
      hold_q <= '0;
    end else if (hold_q != hvsp_pkg::HOLD_CYC) begin
      hold_q <= hold_q + 12'h001; // [RULE_03]
    end
  end

  // link logic held in reset outside programming;
  // link clock is idle at entry so release is safe
  assign link_rst_n = i_rst_n & prog_q;

  // ------------------------------------------------
  // link domain: frame shifting
  // ------------------------------------------------
  // all bits taken on rising serial clock
  always_ff @(posedge i_prog_serial_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_q <= '0;
      din_sh_q <= '0;
      iin_sh_q <= '0;
    end else begin
      din_sh_q <= {din_sh_q[9:0], i_prog_data_in}; // [RULE_19]
      iin_sh_q <= {iin_sh_q[9:0], i_prog_instr_in}; // [RULE_19]
      if (bit_q == hvsp_pkg::FRAME_LAST) begin
        bit_q <= '0;
      end else begin
        bit_q <= bit_q + 4'h1;
      end
    end
  end

  // frame capture: word held stable a whole frame
  always_ff @(posedge i_prog_serial_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      frm_q <= '0;
      frm_tgl_q <= 1'b0;
    end else if (bit_q == hvsp_pkg::FRAME_LAST) begin
      frm_q.data <= din_sh_q[8:1];
      frm_q.instr <= iin_sh_q[8:1];
      frm_tgl_q <= ~frm_tgl_q;
    end
  end

  // read shifter: msb out after first edge, ones after
  // rd_byte_q settles long before the next frame edge
  always_ff @(posedge i_prog_serial_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      out_sh_q <= '1;
    end else if (bit_q == 4'h0) begin
      out_sh_q <= {rd_byte_q, 3'h7}; // [RULE_19]
    end else begin
      out_sh_q <= {out_sh_q[9:0], 1'b1};
    end
  end

  // ------------------------------------------------
  // crossings back to the system clock
  // ------------------------------------------------
  // toggle for frame events, level sync for out bit
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tgl_m_q <= 1'b0;
      tgl_s_q <= 1'b0;
      tgl_d_q <= 1'b0;
      bit_m_q <= 1'b1;
      bit_s_q <= 1'b1;
    end else begin
      tgl_m_q <= frm_tgl_q;
      tgl_s_q <= tgl_m_q;
      tgl_d_q <= tgl_s_q;
      bit_m_q <= out_sh_q[10];
      bit_s_q <= bit_m_q;
    end
  end

  // frm_q is stable whenever the strobe fires
  assign frm_stb = prog_q & (tgl_s_q ^ tgl_d_q);
  assign f_instr = frm_q.instr;
  assign f_data = frm_q.data;

  // ------------------------------------------------
  // command and operand registers
  // ------------------------------------------------
  // command kept until the next command load
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_q <= hvsp_pkg::C_NOP;
    end else if (frm_stb && f_instr == hvsp_pkg::I_LOAD_CMD) begin
      cmd_q <= f_data; // [RULE_07] [RULE_20] [RULE_21]
    end
  end

  // address and data bytes, each kept until reloaded
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_lo_q <= '0;
      addr_hi_q <= '0;
      dlo_q <= '0;
      dhi_q <= '0;
    end else if (frm_stb) begin
      unique case (f_instr)
        hvsp_pkg::I_ADDR_LO: addr_lo_q <= f_data;
        hvsp_pkg::I_ADDR_HI: addr_hi_q <= f_data; // [RULE_08]
        hvsp_pkg::I_DATA_LO: dlo_q <= f_data;
        hvsp_pkg::I_DATA_HI: dhi_q <= f_data;
        default: ;
      endcase
    end
  end

  assign fl_addr = {addr_hi_q[3:0], addr_lo_q};
  assign ee_addr = {addr_hi_q[0], addr_lo_q};

  // write arm and read flags follow each frame
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arm_q <= 1'b0;
      rd_act_q <= 1'b0;
    end else if (frm_stb) begin
      arm_q <= (f_instr == hvsp_pkg::I_WR_LO);
      rd_act_q <= (f_instr == hvsp_pkg::I_RD_LO) ||
                  (f_instr == hvsp_pkg::I_RD_HI);
    end
  end

  // read byte chosen for the following frame
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_byte_q <= hvsp_pkg::ERASED_B;
    end else if (frm_stb && f_instr == hvsp_pkg::I_RD_LO) begin
      if (cmd_q == hvsp_pkg::C_RD_EE) begin
        rd_byte_q <= eep_q[ee_addr]; // [RULE_18]
      end else begin
        rd_byte_q <= flash_q[fl_addr][7:0]; // [RULE_17]
      end
    end else if (frm_stb && f_instr == hvsp_pkg::I_RD_HI) begin
      rd_byte_q <= flash_q[fl_addr][15:8]; // [RULE_17]
    end
  end

  // second write frame launches the selected cycle
  assign start = frm_stb && arm_q && (state_q == hvsp_pkg::ST_IDLE) &&
                 (f_instr == hvsp_pkg::I_WR_HI);

  // ------------------------------------------------
  // page buffers
  // ------------------------------------------------
  // flash buffer refilled with erased words as written;
  // blank at reset too, so unlatched words program as blank
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < hvsp_pkg::FL_PAGE; i++) begin
        fbuf_q[i] <= hvsp_pkg::ERASED_W;
      end
    end else if (state_q == hvsp_pkg::ST_PR_FL) begin
      fbuf_q[cnt_q[4:0]] <= hvsp_pkg::ERASED_W;
    end else if (frm_stb && f_instr == hvsp_pkg::I_FL_LATCH &&
                 cmd_q == hvsp_pkg::C_WR_FLASH) begin
      fbuf_q[addr_lo_q[4:0]] <= {dhi_q, dlo_q}; // [RULE_15]
    end
  end

  // eeprom buffer: only loaded bytes are written
  always_ff @(posedge i_clk_sys) begin
    if (frm_stb && f_instr == hvsp_pkg::I_EE_LATCH &&
        cmd_q == hvsp_pkg::C_WR_EE) begin
      ebuf_q[addr_lo_q[1:0]] <= dlo_q;
    end
  end

  // loaded-byte mask, cleared after the page cycle;
  // a latch in the clearing cycle still sets its bit
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      emask_q <= '0;
    end else begin
      if (state_q == hvsp_pkg::ST_PR_EE && cnt_q == hvsp_pkg::EE_PG_LAST) begin
        emask_q <= '0;
      end
      if (frm_stb && f_instr == hvsp_pkg::I_EE_LATCH &&
          cmd_q == hvsp_pkg::C_WR_EE) begin
        emask_q[addr_lo_q[1:0]] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------
  // erase and programming engine
  // ------------------------------------------------
  // one location per cycle; busy time tracks size
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= hvsp_pkg::ST_IDLE;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 12'h001;
      unique case (state_q)
        hvsp_pkg::ST_IDLE: begin
          cnt_q <= '0;
          if (start) begin
            unique case (cmd_q)
              hvsp_pkg::C_ERASE: state_q <= hvsp_pkg::ST_ER_FL; // [RULE_13]
              hvsp_pkg::C_WR_FLASH: state_q <= hvsp_pkg::ST_PR_FL; // [RULE_14]
              hvsp_pkg::C_WR_EE: state_q <= hvsp_pkg::ST_PR_EE; // [RULE_16]
              default: ;
            endcase
          end
        end
        hvsp_pkg::ST_ER_FL: begin
          if (cnt_q == hvsp_pkg::FL_LAST) begin
            cnt_q <= '0;
            // eeprom skipped when the keep fuse is set
            state_q <= i_keep_eeprom_fuse ? hvsp_pkg::ST_ER_LOCK
                                          : hvsp_pkg::ST_ER_EE; // [RULE_10]
          end
        end
        hvsp_pkg::ST_ER_EE: begin
          if (cnt_q == hvsp_pkg::EE_LAST) begin
            state_q <= hvsp_pkg::ST_ER_LOCK; // [RULE_11]
          end
        end
        hvsp_pkg::ST_ER_LOCK: state_q <= hvsp_pkg::ST_IDLE;
        hvsp_pkg::ST_PR_FL: begin
          if (cnt_q == hvsp_pkg::FL_PG_LAST) begin
            state_q <= hvsp_pkg::ST_IDLE;
          end
        end
        hvsp_pkg::ST_PR_EE: begin
          if (cnt_q == hvsp_pkg::EE_PG_LAST) begin
            state_q <= hvsp_pkg::ST_IDLE;
          end
        end
        default: state_q <= hvsp_pkg::ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------
  // storage arrays
  // ------------------------------------------------
  assign fl_waddr = (state_q == hvsp_pkg::ST_ER_FL) ? cnt_q :
                    {fl_addr[11:5], cnt_q[4:0]};
  assign ee_waddr = (state_q == hvsp_pkg::ST_ER_EE) ? cnt_q[8:0] :
                    {ee_addr[8:2], cnt_q[1:0]};

  // flash: erase sweep or whole page from buffer
  always_ff @(posedge i_clk_sys) begin
    if (state_q == hvsp_pkg::ST_ER_FL) begin
      flash_q[fl_waddr] <= hvsp_pkg::ERASED_W; // [RULE_10]
    end else if (state_q == hvsp_pkg::ST_PR_FL) begin
      flash_q[fl_waddr] <= fbuf_q[cnt_q[4:0]]; // [RULE_15]
    end
  end

  // eeprom: erase sweep or loaded page bytes
  always_ff @(posedge i_clk_sys) begin
    if (state_q == hvsp_pkg::ST_ER_EE) begin
      eep_q[ee_waddr] <= hvsp_pkg::ERASED_B; // [RULE_10]
    end else if (state_q == hvsp_pkg::ST_PR_EE && emask_q[cnt_q[1:0]]) begin
      eep_q[ee_waddr] <= ebuf_q[cnt_q[1:0]];
    end
  end

  // lock bits: cleared only at the end of erase
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_lock_bits <= hvsp_pkg::LOCK_RST;
    end else if (state_q == hvsp_pkg::ST_ER_LOCK) begin
      o_lock_bits <= hvsp_pkg::LOCK_RST; // [RULE_11]
    end else if (start && cmd_q == hvsp_pkg::C_WR_LOCK) begin
      o_lock_bits <= dlo_q;
    end
  end

  // ------------------------------------------------
  // out pin and status
  // ------------------------------------------------
  // low while busy, high when done, data on reads
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prog_data_out <= 1'b0;
      o_prog_data_out_oe <= 1'b0;
      o_prog_mode <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_prog_mode <= prog_q;
      o_busy <= (state_q != hvsp_pkg::ST_IDLE);
      o_prog_data_out_oe <= prog_q && (hold_q == hvsp_pkg::HOLD_CYC); // [RULE_04]
      if (!prog_q) begin
        o_prog_data_out <= 1'b0;
      end else if (rd_act_q) begin
        o_prog_data_out <= bit_s_q; // [RULE_17]
      end else begin
        o_prog_data_out <= (state_q == hvsp_pkg::ST_IDLE); // [RULE_22]
      end
    end
  end

  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  property p_entry;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    hv_rise && pin_s_q[2:0] == 3'h0 |=> ##1 o_prog_mode;
  endproperty
  a_entry: assert property (p_entry) else $error("entry missed"); // [RULE_02]

  property p_exit;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !pin_s_q[3] |=> ##1 !o_prog_mode && !o_prog_data_out_oe;
  endproperty
  a_exit: assert property (p_exit) else $error("exit missed"); // [RULE_06]

  property p_oe;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(prog_q) |=> !o_prog_data_out_oe [*8];
  endproperty
  a_oe: assert property (p_oe) else $error("drive too early"); // [RULE_04]

  property p_cmd;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !(frm_stb && f_instr == hvsp_pkg::I_LOAD_CMD) |=> $stable(cmd_q);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command lost"); // [RULE_07]

  property p_hi;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !(frm_stb && f_instr == hvsp_pkg::I_ADDR_HI) |=> $stable(addr_hi_q);
  endproperty
  a_hi: assert property (p_hi) else $error("high address lost"); // [RULE_08]

  property p_busy;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    state_q != hvsp_pkg::ST_IDLE && !rd_act_q && prog_q |=> !o_prog_data_out;
  endproperty
  a_busy: assert property (p_busy) else $error("out high while busy"); // [RULE_22]

  property p_lock;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    state_q == hvsp_pkg::ST_ER_FL |=> $stable(o_lock_bits);
  endproperty
  a_lock: assert property (p_lock) else $error("lock cleared early"); // [RULE_11]

  property p_keep;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    state_q == hvsp_pkg::ST_ER_FL && cnt_q == hvsp_pkg::FL_LAST && i_keep_eeprom_fuse
    |=> state_q == hvsp_pkg::ST_ER_LOCK;
  endproperty
  a_keep: assert property (p_keep) else $error("eeprom not kept"); // [RULE_10]

  sequence s_pg_start;
    start && cmd_q == hvsp_pkg::C_WR_FLASH;
  endsequence
  property p_page;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    s_pg_start |=> (state_q == hvsp_pkg::ST_PR_FL) [*8] ##25 state_q == hvsp_pkg::ST_IDLE;
  endproperty
  a_page: assert property (p_page) else $error("page cycle length"); // [RULE_15]

  property p_frame;
    @(posedge i_prog_serial_clock) disable iff (!link_rst_n)
    bit_q == hvsp_pkg::FRAME_LAST |=> bit_q == 4'h0 && $changed(frm_tgl_q);
  endproperty
  a_frame: assert property (p_frame) else $error("frame count"); // [RULE_19]
endmodule

// [src/hvsp_pkg.sv]
// Notes on behaviour
// RULE_01: programmer clock period never below 220 ns
// RULE_02: entry when data, instr, out pins read 000
// RULE_03: programmer holds entry pins 10 us
// RULE_04: programmer releases out pin; device then drives
// RULE_05: programmer waits 300 us before first frame; the test model sends it about 10 us after entry
// RULE_06: reset pin at 0 V leaves programming
// RULE_07: loaded command kept until next command load
// RULE_08: high address byte kept until reloaded
// RULE_09: programmer may skip 0xFF writes after erase
// RULE_10: erase clears flash, eeprom, lock; fuses kept; eeprom is skipped when the keep fuse is set
// RULE_11: lock bits cleared only after flash erased
// RULE_12: programmer erases before reprogramming
// RULE_13: erase done when out pin goes high
// RULE_14: flash page programmed, out pin high when done
// RULE_15: flash page buffer written in one cycle; the engine programs it one word per clock, 32 clocks per page
// RULE_16: eeprom page programmed, out pin high when done
// RULE_17: read flash returns low then high byte
// RULE_18: read eeprom shifts stored byte out
// RULE_19: bits sampled and shifted on rising clock
// RULE_20: write flash command code 0x10 via 0x4C
// RULE_21: read flash command code 0x02 via 0x4C
// RULE_22: out pin low while busy, high when done
package hvsp_pkg;
  // ------------------------------------------------
  // timing
  // ------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int T_HOLD_US = 10;
  localparam logic [11:0] HOLD_CYC = 12'(T_HOLD_US * CLK_MHZ);
  // ------------------------------------------------
  // framing and entry
  // ------------------------------------------------
  localparam logic [3:0] FRAME_LAST = 4'h A;
  localparam logic [2:0] ENTRY_SIG = 3'h0;
  // ------------------------------------------------
  // instruction bytes
  // ------------------------------------------------
  localparam logic [7:0] I_LOAD_CMD = 8'h4C;
  localparam logic [7:0] I_ADDR_LO = 8'h0C;
  localparam logic [7:0] I_ADDR_HI = 8'h1C;
  localparam logic [7:0] I_DATA_LO = 8'h2C;
  localparam logic [7:0] I_DATA_HI = 8'h3C;
  localparam logic [7:0] I_FL_LATCH = 8'h7D;
  localparam logic [7:0] I_EE_LATCH = 8'h6D;
  localparam logic [7:0] I_WR_LO = 8'h64;
  localparam logic [7:0] I_WR_HI = 8'h6C;
  localparam logic [7:0] I_RD_LO = 8'h68;
  localparam logic [7:0] I_RD_HI = 8'h78;
  // ------------------------------------------------
  // command codes
  // ------------------------------------------------
  localparam logic [7:0] C_NOP = 8'h00;
  localparam logic [7:0] C_ERASE = 8'h80;
  localparam logic [7:0] C_WR_FLASH = 8'h10;
  localparam logic [7:0] C_RD_FLASH = 8'h02;
  localparam logic [7:0] C_WR_EE = 8'h11;
  localparam logic [7:0] C_RD_EE = 8'h03;
  localparam logic [7:0] C_WR_LOCK = 8'h20;
  // ------------------------------------------------
  // sizes, counts and reset values
  // ------------------------------------------------
  localparam int FL_WORDS = 4096;
  localparam int EE_BYTES = 512;
  localparam int FL_PAGE = 32;
  localparam int EE_PAGE = 4;
  localparam logic [11:0] FL_LAST = 12'hFFF;
  localparam logic [11:0] EE_LAST = 12'h1FF;
  localparam logic [11:0] FL_PG_LAST = 12'h01F;
  localparam logic [11:0] EE_PG_LAST = 12'h003;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam logic [15:0] ERASED_W = 16'hFFFF;
  localparam logic [7:0] ERASED_B = 8'hFF;
  // ------------------------------------------------
  // types
  // ------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] instr;
  } hvsp_frame_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ER_FL, ST_ER_EE, ST_ER_LOCK, ST_PR_FL, ST_PR_EE
  } hvsp_state_t;
endpackage

// [tb/hvsp_prog_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------
// programmer model: drives the link, reads back the out pin
// ------------------------------------------------
module hvsp_prog_model (
  // link pins
  output logic o_sclk,
  output logic o_sdi,
  output logic o_sii,
  output logic o_pin_drv,
  input wire logic i_out,
  // byte read back in the last frame
  output logic [7:0] o_rd
);
  initial begin
    o_sclk = 1'b0; // clock stands still outside frames
    o_sdi = 1'b0; // entry pattern 000
    o_sii = 1'b0;
    o_pin_drv = 1'b1; // out pin held low until released
    o_rd = 8'h00;
  end
  // entry pins and out pin drive
  task automatic pins(input logic d, input logic drv);
    o_sdi = d;
    o_pin_drv = drv; // released after the hold time
  endtask
  // one frame: start 0, byte msb first, two 0 tail
  // half period 125 ns keeps the 220 ns floor on the period
  task automatic frame(input logic [7:0] d, input logic [7:0] ins);
    logic [10:0] sd;
    logic [10:0] si;
    sd = {1'b0, d, 2'b00};
    si = {1'b0, ins, 2'b00};
    for (int i = 10; i >= 0; i--) begin
      o_sdi = sd[i];
      o_sii = si[i];
      #125 o_sclk = 1'b1;
      #125 o_sclk = 1'b0;
      // read byte appears msb first after each early edge
      if (i > 2) o_rd[i - 3] = i_out;
    end
  endtask
endmodule

// [tb/test_hvsp_port.sv]
`timescale 1ns/1ps
module test_hvsp_port;
  // ------------------------------------------------
  // clock, pins and counters
  // ------------------------------------------------
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic hv = 1'b0;
  logic fuse = 1'b0;
  logic sclk, prog_data_in, prog_instr_in, drv, out, oe, mode, busy, pin;
  logic [7:0] lock, rd, lo;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  // out pin: programmer, else device, else pulled up
  assign pin = drv ? 1'b0 : (oe ? out : 1'b1);
  hvsp_prog_model u_prog (.o_sclk(sclk), .o_sdi(prog_data_in), .o_sii(prog_instr_in), .o_pin_drv(drv), .i_out(pin), .o_rd(rd));
  hvsp_port DUT (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_hv_reset(hv), .i_keep_eeprom_fuse(fuse),
    .i_prog_serial_clock(sclk), .i_prog_data_in(prog_data_in), .i_prog_instr_in(prog_instr_in), .i_prog_data_out(pin),
    .o_prog_data_out(out), .o_prog_data_out_oe(oe), .o_prog_mode(mode), .o_busy(busy), .o_lock_bits(lock));
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    u_prog.frame(c, 8'h4C);
  endtask
  // start a cycle: out pin low, busy high; watched during the frames,
  // since an eeprom page cycle is over before the last frame ends
  task automatic go();
    fork
      begin
        u_prog.frame(8'h00, 8'h64);
        u_prog.frame(8'h00, 8'h6C);
      end
      begin
        for (int i = 0; i < 1200 && busy !== 1'b1; i++) @(negedge i_clk_sys);
        chk(16'(pin), 16'h0000);
        chk(16'(busy), 16'h0001);
      end
    join
  endtask
  // bounded wait for the out pin to rise
  task automatic done();
    for (int i = 0; i < 6000 && pin !== 1'b1; i++) @(negedge i_clk_sys);
    chk(16'(pin), 16'h0001);
  endtask
  task automatic ld(input logic [7:0] a, input logic [15:0] d);
    u_prog.frame(a, 8'h0C);
    u_prog.frame(d[7:0], 8'h2C);
    u_prog.frame(d[15:8], 8'h3C);
    u_prog.frame(8'h00, 8'h7D);
  endtask
  task automatic rf(input logic [7:0] a, input logic [15:0] exp);
    u_prog.frame(a, 8'h0C);
    u_prog.frame(8'h00, 8'h68);
    u_prog.frame(8'h00, 8'h6C);
    lo = rd;
    u_prog.frame(8'h00, 8'h78);
    u_prog.frame(8'h00, 8'h7C);
    chk({rd, lo}, exp);
  endtask
  task automatic re(input logic [7:0] exp);
    cmd(8'h03);
    u_prog.frame(8'h02, 8'h0C);
    u_prog.frame(8'h00, 8'h68);
    u_prog.frame(8'h00, 8'h6C);
    chk(16'(rd), 16'(exp));
  endtask
  // run ceiling, roughly twice the expected length
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      stop_test();
    end
  end
  // ------------------------------------------------
  // tests
  // ------------------------------------------------
  initial begin
    repeat (6) @(negedge i_clk_sys);
    chk(16'(lock), 16'h00FF);
    i_rst_n = 1'b1;
    u_prog.pins(1'b1, 1'b1);
    hv = 1'b1;
    repeat (10) @(negedge i_clk_sys);
    chk(16'(mode), 16'h0000);
    hv = 1'b0;
    repeat (10) @(negedge i_clk_sys);
    u_prog.pins(1'b0, 1'b1);
    hv = 1'b1;
    repeat (6) @(negedge i_clk_sys);
    chk(16'(mode), 16'h0001);
    repeat (1995) @(negedge i_clk_sys);
    u_prog.pins(1'b0, 1'b0);
    // first frame only once the device drives the pin
    for (int i = 0; i < 300 && oe !== 1'b1; i++) @(negedge i_clk_sys);
    chk(16'(oe), 16'h0001);
    chk(16'(pin), 16'h0001);
    $display("entry test done");
    cmd(8'h20);
    u_prog.frame(8'h3C, 8'h2C);
    // lock write is no erase or page cycle: no busy phase
    u_prog.frame(8'h00, 8'h64);
    u_prog.frame(8'h00, 8'h6C);
    repeat (8) @(negedge i_clk_sys);
    chk(16'(busy), 16'h0000);
    done();
    chk(16'(lock), 16'h003C);
    cmd(8'h80);
    go();
    chk(16'(lock), 16'h003C);
    done();
    chk(16'(lock), 16'h00FF);
    cmd(8'h00);
    $display("erase test done");
    cmd(8'h10);
    ld(8'h05, 16'h1234);
    ld(8'h06, 16'hABCD);
    u_prog.frame(8'h01, 8'h1C);
    go();
    done();
    cmd(8'h02);
    rf(8'h05, 16'h1234);
    rf(8'h06, 16'hABCD);
    rf(8'h07, 16'hFFFF);
    $display("flash test done");
    cmd(8'h11);
    u_prog.frame(8'h02, 8'h0C);
    u_prog.frame(8'h00, 8'h1C);
    u_prog.frame(8'h5A, 8'h2C);
    u_prog.frame(8'h00, 8'h6D);
    go();
    done();
    re(8'h5A);
    $display("eeprom test done");
    @(negedge i_clk_sys);
    fuse = 1'b1;
    cmd(8'h80);
    go();
    done();
    re(8'h5A);
    cmd(8'h02);
    u_prog.frame(8'h01, 8'h1C);
    rf(8'h05, 16'hFFFF);
    @(negedge i_clk_sys);
    hv = 1'b0;
    repeat (10) @(negedge i_clk_sys);
    chk(16'(mode), 16'h0000);
    $display("keep and exit test done");
    stop_test();
  end
endmodule
